// ---- pwio_defs.svh ----
/*
  Constants of the parallel word I/O unit: register selects, control/status
  bit positions, reset values, default straps and pulse timing.
  Assumes it is included by bare name into the modules that need it.
*/
`ifndef PWIO_DEFS_SVH
`define PWIO_DEFS_SVH

// ==========================================================
// Register selects from bus address bits 2:1
`define PWIO_SEL_CSR 2'h0
`define PWIO_SEL_OUT 2'h1
`define PWIO_SEL_IN 2'h2
`define PWIO_SEL_NONE 2'h3

// ==========================================================
// Control/status bit positions
`define PWIO_CSR_REQ_B 15
`define PWIO_CSR_REQ_A 7
`define PWIO_CSR_EN_A 6
`define PWIO_CSR_EN_B 5
`define PWIO_CSR_CMD1 1
`define PWIO_CSR_CMD0 0
`define PWIO_CSR_UNUSED 16'h7F1C

// ==========================================================
// Reset values and default straps (control/status at 167770, vector 300)
`define PWIO_WORD_RST 16'h0000
`define PWIO_DEF_ADDR_STRAP 10'h1FF
`define PWIO_DEF_VEC_STRAP 5'h18

// ==========================================================
// Pulse timing: 300 ns at a 4 ns clock, least time rounded up
`define PWIO_PULSE_NS 300
`define PWIO_CLK_NS 4
`define PWIO_PULSE_CYC ((`PWIO_PULSE_NS + `PWIO_CLK_NS - 1) / `PWIO_CLK_NS)

`endif

// ---- pwio_pkg.sv ----
/*
  Types of the parallel word I/O unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pwio_pkg;
  // ==========================================================
  // Bus slave states
  typedef enum logic [0:0] {
    PWIO_IDLE = 1'b0,
    PWIO_REPLY = 1'b1
  } pwio_bus_state_t;
endpackage : pwio_pkg

// ---- pwio_skid.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock, asynchronous active-low reset, synchronous flush.
*/
`timescale 1ns/1ps
module pwio_skid #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wr_ptr_q, rd_ptr_q;
  logic [1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // ==========================================================
  // Width check
  initial begin
    if (W < 1) begin
      $error("pwio_skid: width must be positive");
    end
  end

  // Honest full and empty from the entry count
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  // ==========================================================
  // Storage, no reset needed on the data words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (flush) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : pwio_skid

// ---- pwio_unit.sv ----
/*
  Parallel word I/O unit: output word buffer with loaded pulse, unstored
  input gate with accepted pulse, two request lines with vectored interrupts.
  Assumes a word-wide handshaked host bus, synchronous pins, straps held static.
*/
`timescale 1ns/1ps
`include "pwio_defs.svh"
module pwio_unit import pwio_pkg::*; #(
  parameter int DATA_W = 16,
  parameter int PULSE_CYC = `PWIO_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic system_initialize_in,
  input wire logic [15:0] bus_addr,
  input wire logic bus_io_page,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [DATA_W-1:0] bus_wdata,
  output logic [DATA_W-1:0] bus_rdata,
  output logic bus_reply,
  output logic irq_req,
  input wire logic irq_ack,
  output logic [15:0] irq_vector,
  output logic irq_vector_valid,
  input wire logic [12:3] address_strap,
  input wire logic [7:3] vector_strap,
  input wire logic [DATA_W-1:0] input_lines,
  output logic [DATA_W-1:0] output_lines,
  input wire logic user_out_ready,
  output logic output_loaded_pulse,
  output logic input_accepted_pulse,
  input wire logic first_request_in,
  input wire logic second_request_in,
  input wire logic loopback_en,
  output logic user_command_bit_zero,
  output logic user_command_bit_one
);
  // ==========================================================
  // Elaboration checks: layout is fixed at one 16-bit word
  initial begin
    if (DATA_W != 16) begin
      $error("pwio_unit: DATA_W must be 16");
    end
    if (PULSE_CYC < 1 || PULSE_CYC > 127) begin
      $error("pwio_unit: PULSE_CYC out of range");
    end
  end

  pwio_bus_state_t state_q, state_d;
  logic [DATA_W-1:0] out_word_q, rdata_q, lines_q, vec_q;
  logic reply_q, en_a_q, en_b_q, cmd0_q, cmd1_q;
  logic pend_a_q, pend_b_q, arm_a_q, arm_b_q, irq_q, vec_valid_q;
  logic [12:3] addr_strap_q;
  logic [7:3] vec_strap_q;
  logic skid_ready, skid_valid;
  logic [DATA_W-1:0] skid_data;
  logic [1:0] pulse_start, pulse_q;

  // ==========================================================
  // Strap capture, resampled on every clock after reset release
  // default strap pattern
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_strap_q <= `PWIO_DEF_ADDR_STRAP;
      vec_strap_q <= `PWIO_DEF_VEC_STRAP;
    end else begin
      addr_strap_q <= address_strap;
      vec_strap_q <= vector_strap;
    end
  end

  // ==========================================================
  // Address decode and register select
  wire [1:0] sel = bus_addr[2:1];
  wire base_hit = bus_io_page && (bus_addr[12:3] == addr_strap_q);
  wire hit = base_hit && (sel != `PWIO_SEL_NONE);
  wire strobe = bus_rd || bus_wr;
  // A full buffer holds off the reply, so no output word is dropped
  wire out_block = bus_wr && (sel == `PWIO_SEL_OUT) && !skid_ready;
  wire take = (state_q == PWIO_IDLE) && strobe && hit && !out_block && !system_initialize_in;
  wire wr_csr = take && bus_wr && (sel == `PWIO_SEL_CSR);
  wire wr_out = take && bus_wr && (sel == `PWIO_SEL_OUT);
  wire rd_in = take && bus_rd && (sel == `PWIO_SEL_IN);

  // ==========================================================
  // Request levels; loopback mirrors command bits
  // loopback of command bits
  wire lvl_a = loopback_en ? cmd0_q : first_request_in;
  wire lvl_b = loopback_en ? cmd1_q : second_request_in;
  wire [15:0] csr_img = {lvl_b, 7'h00, lvl_a, en_a_q, en_b_q, 3'h0, cmd1_q, cmd0_q};
  // input gate is the live line level, never stored
  wire [DATA_W-1:0] rd_mux = (sel == `PWIO_SEL_CSR) ? csr_img :
                             (sel == `PWIO_SEL_OUT) ? out_word_q : input_lines;

  // ==========================================================
  // Bus slave state
  always_comb begin
    state_d = state_q;
    case (state_q)
      PWIO_IDLE: begin
        if (take) begin
          state_d = PWIO_REPLY;
        end
      end
      PWIO_REPLY: begin
        if (!strobe) begin
          state_d = PWIO_IDLE;
        end
      end
      default: begin
        state_d = PWIO_IDLE;
      end
    endcase
  end

  // Reply and read data stand until the strobe drops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PWIO_IDLE;
      reply_q <= 1'b0;
      rdata_q <= `PWIO_WORD_RST;
    end else begin
      state_q <= state_d;
      reply_q <= (state_d == PWIO_REPLY);
      rdata_q <= take ? (bus_rd ? rd_mux : `PWIO_WORD_RST) : (state_d == PWIO_REPLY) ? rdata_q : `PWIO_WORD_RST;
    end
  end

  // ==========================================================
  // Host registers: output word and control/status fields
  // writes and initialize
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_word_q <= `PWIO_WORD_RST;
      {en_a_q, en_b_q, cmd1_q, cmd0_q} <= 4'h0;
    end else if (system_initialize_in) begin
      out_word_q <= `PWIO_WORD_RST;
      {en_a_q, en_b_q, cmd1_q, cmd0_q} <= 4'h0;
    end else begin
      if (wr_out) begin
        out_word_q <= bus_wdata;
      end
      if (wr_csr) begin
        en_a_q <= bus_wdata[`PWIO_CSR_EN_A];
        en_b_q <= bus_wdata[`PWIO_CSR_EN_B];
        cmd1_q <= bus_wdata[`PWIO_CSR_CMD1];
        cmd0_q <= bus_wdata[`PWIO_CSR_CMD0];
      end
    end
  end

  // ==========================================================
  // Output path: buffer drains one word per finished pulse
  pwio_skid #(.W(DATA_W)) u_skid (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .flush(system_initialize_in),
    .in_valid(wr_out),
    .in_ready(skid_ready),
    .in_data(bus_wdata),
    .out_valid(skid_valid),
    .out_ready(pulse_start[0]),
    .out_data(skid_data)
  );

  // a new word waits for the previous trailing edge
  assign pulse_start[0] = skid_valid && user_out_ready && !pulse_q[0] && !system_initialize_in;
  // read of the input gate starts the accepted pulse
  assign pulse_start[1] = rd_in;

  // output lines follow each drained word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lines_q <= `PWIO_WORD_RST;
    end else if (system_initialize_in) begin
      lines_q <= `PWIO_WORD_RST;
    end else if (pulse_start[0]) begin
      lines_q <= skid_data;
    end
  end

  // ==========================================================
  // Pulse generators; a retrigger restarts the full width
  for (genvar i = 0; i < 2; i++) begin : g_pulse
    logic [6:0] cnt_q;
    logic [6:0] len_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        pulse_q[i] <= 1'b0;
        cnt_q <= 7'h00;
      end else if (pulse_start[i]) begin
        pulse_q[i] <= 1'b1;
        cnt_q <= 7'(PULSE_CYC);
      end else if (pulse_q[i]) begin
        pulse_q[i] <= (cnt_q != 7'h01);
        cnt_q <= cnt_q - 7'h01;
      end
    end
    // Helper: length of the current high run, read only by checks
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        len_q <= 7'h00;
      end else begin
        len_q <= pulse_start[i] ? 7'h00 : (pulse_q[i] ? len_q + 7'h01 : 7'h00);
      end
    end
  end

  // ==========================================================
  // Interrupt request flops; the set wins over an acknowledge
  wire arm_a = lvl_a && en_a_q;
  wire arm_b = lvl_b && en_b_q;
  wire rise_a = arm_a && !arm_a_q;
  wire rise_b = arm_b && !arm_b_q;
  wire ack_a = irq_ack && pend_a_q;
  wire ack_b = irq_ack && !pend_a_q && pend_b_q;
  wire pend_a_d = rise_a || (pend_a_q && !ack_a);
  wire pend_b_d = rise_b || (pend_b_q && !ack_b);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {pend_a_q, pend_b_q, arm_a_q, arm_b_q, irq_q, vec_valid_q} <= 6'h00;
      vec_q <= `PWIO_WORD_RST;
    end else if (system_initialize_in) begin
      {pend_a_q, pend_b_q, arm_a_q, arm_b_q, irq_q, vec_valid_q} <= 6'h00;
      vec_q <= `PWIO_WORD_RST;
    end else begin
      pend_a_q <= pend_a_d;
      pend_b_q <= pend_b_d;
      arm_a_q <= arm_a;
      arm_b_q <= arm_b;
      irq_q <= pend_a_d || pend_b_d;
      vec_valid_q <= ack_a || ack_b;
      if (ack_a || ack_b) begin
        // strap bits 7..3, bit 2 picks the source
        vec_q <= {8'h00, vec_strap_q, ack_b, 2'h0};
      end
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign bus_rdata = rdata_q;
  assign bus_reply = reply_q;
  assign irq_req = irq_q;
  assign irq_vector = vec_q;
  assign irq_vector_valid = vec_valid_q;
  assign output_lines = lines_q;
  assign output_loaded_pulse = pulse_q[0];
  assign input_accepted_pulse = pulse_q[1];
  assign user_command_bit_zero = cmd0_q;
  assign user_command_bit_one = cmd1_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_out_len;
    $fell(output_loaded_pulse) |-> g_pulse[0].len_q == 7'(PULSE_CYC);
  endproperty
  a_out_len: assert property (p_out_len) else $error("loaded pulse width wrong");

  property p_acc_len;
    $fell(input_accepted_pulse) |-> g_pulse[1].len_q == 7'(PULSE_CYC);
  endproperty
  a_acc_len: assert property (p_acc_len) else $error("accepted pulse width wrong");

  property p_lines_pulse;
    $changed(output_lines) && !$past(system_initialize_in) |-> $rose(output_loaded_pulse);
  endproperty
  a_lines_pulse: assert property (p_lines_pulse) else $error("lines changed without pulse");

  property p_rd_pulse;
    bus_rd && take && sel == `PWIO_SEL_IN |=> input_accepted_pulse && g_pulse[1].len_q == 7'h00
      && bus_rdata == $past(input_lines);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("input read without pulse");

  property p_init;
    system_initialize_in |=> output_lines == 16'h0000 && out_word_q == 16'h0000 && !irq_req
      && !en_a_q && !en_b_q && !user_command_bit_zero && !user_command_bit_one;
  endproperty
  a_init: assert property (p_init) else $error("initialize left state");

  property p_csr_read;
    take && bus_rd && sel == `PWIO_SEL_CSR |=> (bus_rdata & `PWIO_CSR_UNUSED) == 16'h0000
      && bus_rdata[`PWIO_CSR_REQ_B] == $past(lvl_b) && bus_rdata[`PWIO_CSR_REQ_A] == $past(lvl_a);
  endproperty
  a_csr_read: assert property (p_csr_read) else $error("status read image wrong");

  property p_no_six;
    bus_io_page && bus_addr[12:3] == addr_strap_q && bus_addr[2:1] == `PWIO_SEL_NONE && strobe && !bus_reply
      |=> !bus_reply;
  endproperty
  a_no_six: assert property (p_no_six) else $error("offset six answered");

  property p_prio;
    irq_ack && pend_a_q && pend_b_q && !system_initialize_in
      |=> irq_vector_valid && irq_vector[2:0] == 3'h0 && pend_b_q ##1 !irq_vector_valid;
  endproperty
  a_prio: assert property (p_prio) else $error("priority or vector wrong");

  property p_raise;
    rise_a && !irq_ack && !system_initialize_in |=> irq_req && pend_a_q;
  endproperty
  a_raise: assert property (p_raise) else $error("enabled request not raised");

  property p_addr;
    $rose(bus_reply) |-> $past(bus_addr[12:3]) == $past(addr_strap_q) && $past(bus_io_page);
  endproperty
  a_addr: assert property (p_addr) else $error("reply to foreign address");
endmodule : pwio_unit

// ---- pwio_user_model.sv ----
/*
  User device model for the parallel word I/O unit: takes output words,
  offers input words and raises the two request lines.
  Assumes the bench changes its controls just after rising clock edges.
*/
`timescale 1ns/1ps
module pwio_user_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] output_lines,
  input wire logic output_loaded_pulse,
  input wire logic input_accepted_pulse,
  input wire logic stall,
  input wire logic [15:0] in_word,
  input wire logic load,
  input wire logic raise_a,
  input wire logic raise_b,
  output logic user_out_ready,
  output logic [15:0] input_lines,
  output logic first_request_in,
  output logic second_request_in,
  output logic [15:0] got_word_q,
  output int got_count_q,
  output int out_width_q,
  output int acc_width_q
);
  logic out_p_q;
  logic acc_p_q;
  logic taken_q;
  int out_cnt_q;
  int acc_cnt_q;

  // ==========================================================
  // Port levels
  assign user_out_ready = !stall;
  // word held until accepted pulse ends
  assign input_lines = taken_q ? ~in_word : in_word;

  // ==========================================================
  // Pulse watch and requests; stale input is inverted so it cannot pass
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      taken_q <= 1'b0;
      first_request_in <= 1'b0;
      second_request_in <= 1'b0;
      got_count_q <= 0;
      got_word_q <= 16'h0000;
    end else begin
      out_p_q <= output_loaded_pulse;
      acc_p_q <= input_accepted_pulse;
      out_cnt_q <= output_loaded_pulse ? out_cnt_q + 1 : 0;
      acc_cnt_q <= input_accepted_pulse ? acc_cnt_q + 1 : 0;
      if (out_p_q && !output_loaded_pulse) begin
        got_word_q <= output_lines;
        got_count_q <= got_count_q + 1;
        out_width_q <= out_cnt_q;
      end
      if (acc_p_q && !input_accepted_pulse) begin
        taken_q <= 1'b1;
        acc_width_q <= acc_cnt_q;
      end
      if (load) taken_q <= 1'b0;
      if (raise_a) first_request_in <= 1'b1;
      else if (output_loaded_pulse || input_accepted_pulse) first_request_in <= 1'b0;
      if (raise_b) second_request_in <= 1'b1;
      else if (output_loaded_pulse || input_accepted_pulse) second_request_in <= 1'b0;
    end
  end
endmodule : pwio_user_model

// ---- test_parallel_word_io_unit.sv ----
/*
  Self-checking bench for the parallel word I/O unit with a user device model.
  Assumes default straps and a shortened pulse parameter.
*/
`timescale 1ns/1ps
`include "pwio_defs.svh"
module test_parallel_word_io_unit import pwio_pkg::*;;
  localparam int PC = 4;
  localparam logic [15:0] A_CSR = 16'hEFF8;
  localparam logic [15:0] A_OUT = 16'hEFFA;
  localparam logic [15:0] A_IN = 16'hEFFC;
  logic core_clk = 1'b0, reset_n = 1'b0, system_initialize_in = 1'b0, bus_io_page = 1'b1;
  logic bus_rd = 1'b0, bus_wr = 1'b0, irq_ack = 1'b0, loopback_en = 1'b0, stall = 1'b0;
  logic load = 1'b0, raise_a = 1'b0, raise_b = 1'b0;
  logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, in_word = 16'h0000, rv;
  logic [12:3] address_strap = `PWIO_DEF_ADDR_STRAP;
  logic [7:3] vector_strap = `PWIO_DEF_VEC_STRAP;
  logic [15:0] bus_rdata, irq_vector, input_lines, output_lines, got_word_q;
  logic bus_reply, irq_req, irq_vector_valid, user_out_ready, output_loaded_pulse;
  logic input_accepted_pulse, first_request_in, second_request_in;
  logic user_command_bit_zero, user_command_bit_one;
  int got_count_q, out_width_q, acc_width_q, errors = 0, checked = 0, cyc = 0, sent = 0;

  pwio_unit #(.PULSE_CYC(PC)) dut (.core_clk, .reset_n, .system_initialize_in, .bus_addr, .bus_io_page,
    .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .bus_reply, .irq_req, .irq_ack, .irq_vector,
    .irq_vector_valid, .address_strap, .vector_strap, .input_lines, .output_lines, .user_out_ready,
    .output_loaded_pulse, .input_accepted_pulse, .first_request_in, .second_request_in,
    .loopback_en, .user_command_bit_zero, .user_command_bit_one);
  pwio_user_model user (.core_clk, .reset_n, .output_lines, .output_loaded_pulse,
    .input_accepted_pulse, .stall, .in_word, .load, .raise_a, .raise_b, .user_out_ready,
    .input_lines, .first_request_in, .second_request_in, .got_word_q, .got_count_q,
    .out_width_q, .acc_width_q);

  // ==========================================================
  // Clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Host cycle: strobe held until reply seen, a missing reply gives up after 60 cycles
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d, input logic exp,
                     output logic [15:0] r);
    int n;
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= w;
    bus_rd <= !w;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (bus_reply !== 1'b1 && n < 60);
    r = bus_rdata;
    check("reply", {15'h0000, bus_reply}, {15'h0000, exp});
    @(posedge core_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : bus

  task automatic rdc(input string what, input logic [15:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, 1'b1, rv);
    check(what, rv, exp);
  endtask : rdc

  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (got_count_q != n && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    check("got count", got_count_q[15:0], n[15:0]);
  endtask : wait_got

  task automatic ack_chk(input logic [15:0] exp);
    @(posedge core_clk);
    irq_ack <= 1'b1;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    @(negedge core_clk);
    check("vector valid", {15'h0000, irq_vector_valid}, 16'h0001);
    check("vector", irq_vector, exp);
  endtask : ack_chk

  task automatic report_and_stop;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Scenarios
  task automatic t_output;
    bus(1'b1, A_OUT, 16'hA5A5, 1'b1, rv);
    sent++;
    rdc("out readback", A_OUT, 16'hA5A5);
    wait_got(sent);
    check("user word", got_word_q, 16'hA5A5);
    check("out lines", output_lines, 16'hA5A5);
    check("loaded width", out_width_q[15:0], PC[15:0]);
  endtask : t_output

  // Receiver stall fills both entries; the third write must wait, nothing lost
  task automatic t_buffer;
    logic [15:0] w [3];
    int base;
    w = '{16'h1111, 16'h2222, 16'h3333};
    base = sent;
    @(posedge core_clk);
    stall <= 1'b1;
    bus(1'b1, A_OUT, w[0], 1'b1, rv);
    bus(1'b1, A_OUT, w[1], 1'b1, rv);
    fork
      bus(1'b1, A_OUT, w[2], 1'b1, rv);
      begin
        repeat (15) @(negedge core_clk);
        check("stalled reply", {15'h0000, bus_reply}, 16'h0000);
        @(posedge core_clk);
        stall <= 1'b0;
      end
    join
    for (int i = 0; i < 3; i++) begin
      wait_got(base + i + 1);
      check("order", got_word_q, w[i]);
    end
    sent = base + 3;
  endtask : t_buffer

  task automatic t_input;
    @(posedge core_clk);
    in_word <= 16'h1234;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
    rdc("input gate", A_IN, 16'h1234);
    repeat (PC + 4) @(negedge core_clk);
    check("accepted width", acc_width_q[15:0], PC[15:0]);
    bus(1'b1, A_IN, 16'hFFFF, 1'b1, rv);
    rdc("live input", A_IN, 16'hEDCB);
  endtask : t_input

  task automatic t_loopback;
    @(posedge core_clk);
    loopback_en <= 1'b1;
    bus(1'b1, A_CSR, 16'hFF9F, 1'b1, rv);
    rdc("csr loop", A_CSR, 16'h8083);
    check("cmd bits", {14'h0000, user_command_bit_one, user_command_bit_zero}, 16'h0003);
    bus(1'b1, A_CSR, 16'h0001, 1'b1, rv);
    rdc("csr loop zero", A_CSR, 16'h0081);
    bus(1'b1, A_CSR, 16'h0000, 1'b1, rv);
    @(posedge core_clk);
    loopback_en <= 1'b0;
  endtask : t_loopback

  task automatic t_irq;
    bus(1'b1, A_CSR, 16'h0060, 1'b1, rv);
    rdc("enables", A_CSR, 16'h0060);
    @(posedge core_clk);
    raise_a <= 1'b1;
    raise_b <= 1'b1;
    @(posedge core_clk);
    raise_a <= 1'b0;
    raise_b <= 1'b0;
    repeat (3) @(negedge core_clk);
    check("irq both", {15'h0000, irq_req}, 16'h0001);
    rdc("request bits", A_CSR, 16'h80E0);
    ack_chk(16'h00C0);
    check("irq second left", {15'h0000, irq_req}, 16'h0001);
    ack_chk(16'h00C4);
    check("irq done", {15'h0000, irq_req}, 16'h0000);
    bus(1'b1, A_OUT, 16'h0F0F, 1'b1, rv);
    sent++;
    wait_got(sent);
    bus(1'b1, A_CSR, 16'h0000, 1'b1, rv);
    @(posedge core_clk);
    raise_a <= 1'b1;
    @(posedge core_clk);
    raise_a <= 1'b0;
    repeat (4) @(negedge core_clk);
    check("irq masked", {15'h0000, irq_req}, 16'h0000);
    rdc("flag only", A_CSR, 16'h0080);
    bus(1'b1, A_CSR, 16'h0040, 1'b1, rv);
    repeat (2) @(negedge core_clk);
    check("irq unmasked", {15'h0000, irq_req}, 16'h0001);
    @(posedge core_clk);
    vector_strap <= 5'h07;
    ack_chk(16'h0038);
    @(posedge core_clk);
    vector_strap <= `PWIO_DEF_VEC_STRAP;
  endtask : t_irq

  task automatic t_unmapped;
    bus(1'b0, 16'hEFFE, 16'h0000, 1'b0, rv);
    bus(1'b0, 16'hEFB8, 16'h0000, 1'b0, rv);
    @(posedge core_clk);
    address_strap <= 10'h1FE;
    rdc("moved csr", 16'hEFF0, 16'h00C0);
    bus(1'b0, A_CSR, 16'h0000, 1'b0, rv);
    @(posedge core_clk);
    address_strap <= `PWIO_DEF_ADDR_STRAP;
  endtask : t_unmapped

  task automatic t_init;
    bus(1'b1, A_CSR, 16'h0043, 1'b1, rv);
    @(posedge core_clk);
    system_initialize_in <= 1'b1;
    @(posedge core_clk);
    system_initialize_in <= 1'b0;
    repeat (2) @(negedge core_clk);
    check("init lines", output_lines, 16'h0000);
    check("init irq", {15'h0000, irq_req}, 16'h0000);
    check("init cmd", {15'h0000, user_command_bit_zero}, 16'h0000);
    rdc("init csr", A_CSR, 16'h0080);
    rdc("init out", A_OUT, 16'h0000);
  endtask : t_init

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdc("csr reset", A_CSR, 16'h0000);
    rdc("out reset", A_OUT, 16'h0000);
    t_output();
    t_buffer();
    t_input();
    t_loopback();
    t_irq();
    t_unmapped();
    t_init();
    report_and_stop();
  end
endmodule : test_parallel_word_io_unit
